// ---- bscc_defines.vh ----
// Purpose: constants for the skip, call and clear decode block
// Assumes: 12-bit instruction words, 11-bit program counter
// Notes: included by both design files
`ifndef BSCC_DEFINES_VH
`define BSCC_DEFINES_VH
`define OP_SKIP_SET 4'h7
`define OP_SKIP_CLR 4'h6
`define OP_CALL 4'h9
`define OP_CLEAR_HI 7'h03
`define NOP_WORD 12'h000
`define ST_PAGE_HI 6
`define ST_PAGE_LO 5
`define ST_ZERO 2
`define PC_RESET 11'h000
`endif

// ---- op_classify.v ----
// Purpose: classify one instruction word for the decode block
// Assumes: plain combinational logic on the execute word
// Notes: other opcodes classify as none of the four
`timescale 1ns/1ps
`default_nettype none
`include "bscc_defines.vh"
module op_classify (
  // instruction word
  input wire [11:0] instr_i,
  // class outputs
  output reg skip_set_o,
  output reg skip_clr_o,
  output reg call_o,
  output reg clear_o
);

  // decode the top bits of the word
  always @* begin
    skip_set_o = (instr_i[11:8] == `OP_SKIP_SET);
    skip_clr_o = (instr_i[11:8] == `OP_SKIP_CLR);
    call_o = (instr_i[11:8] == `OP_CALL);
    clear_o = (instr_i[11:5] == `OP_CLEAR_HI);
  end

endmodule
`default_nettype wire

// ---- bit_skip_call_clear_decode.v ----
// Purpose: execute bit-test skips, subroutine call and register clear
// Assumes: fetch pipeline gives one word per cycle with its address
// Notes: stack and register file live outside; outputs are registered
`timescale 1ns/1ps
`default_nettype none
`include "bscc_defines.vh"
module bit_skip_call_clear_decode (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // fetch pipeline
  input wire instr_valid_i,
  input wire [11:0] instr_i,
  input wire [10:0] instr_addr_i,
  // register file read of the addressed register
  input wire [7:0] file_rdata_i,
  // status register
  input wire [7:0] status_i,
  // register file write
  output reg file_we_o,
  output reg [4:0] file_waddr_o,
  output reg [7:0] file_wdata_o,
  // status zero flag set strobe
  output reg zero_set_o,
  // stack push to stack_top
  output reg stack_push_o,
  output reg [10:0] stack_top_o,
  // program counter load and fetch flush
  output reg pc_load_o,
  output reg [10:0] program_counter_o,
  output reg flush_o,
  // word actually executed this cycle (no-op when flushed)
  output reg [11:0] exec_word_o
);

  wire skip_if_bit_set_op;
  wire skip_if_bit_clear_op;
  wire call_op;
  wire clear_file_reg_op;
  reg kill_q;
  reg kill_d;
  wire live;
  wire bit_val;
  // next values of the registered outputs
  reg push_d;
  reg clear_d;
  reg [11:0] word_d;
  reg [10:0] ret_d;
  reg [10:0] target_d;

  op_classify u_cls (
    .instr_i(instr_i),
    .skip_set_o(skip_if_bit_set_op),
    .skip_clr_o(skip_if_bit_clear_op),
    .call_o(call_op),
    .clear_o(clear_file_reg_op)
  );

  // return address: the word that follows the one in execute
  function [10:0] next_addr;
    input [10:0] addr;
    begin
      next_addr = addr + 11'h001;
    end
  endfunction

  // call target built from page bits, a zero and the literal
  function [10:0] call_target;
    input [7:0] status;
    input [7:0] literal;
    begin
      call_target = {status[`ST_PAGE_HI:`ST_PAGE_LO],
                     1'b0,
                     literal};
    end
  endfunction

  // pick one bit of a register by its three-bit index
  function bit_pick;
    input [7:0] data;
    input [2:0] index;
    begin
      bit_pick = data[index];
    end
  endfunction

  // a word following a taken skip or a call is discarded
  assign live = instr_valid_i & ~kill_q;
  // the register file answers combinationally for the word in execute
  assign bit_val = bit_pick(file_rdata_i, instr_i[7:5]);

  // decide whether the next fetched word must be killed
  always @* begin
    kill_d = 1'b0;
    if (live && skip_if_bit_set_op && bit_val) begin
      kill_d = 1'b1;
    end
    if (live && skip_if_bit_clear_op && !bit_val) begin
      kill_d = 1'b1;
    end
    if (live && call_op) begin
      kill_d = 1'b1;
    end
    if (kill_q && !instr_valid_i) begin
      kill_d = 1'b1; // hold until the doomed word arrives
    end
  end

  // strobes and data for the next cycle
  // skips that fall through raise no strobe and touch no flag
  always @* begin
    push_d = live & call_op;
    clear_d = live & clear_file_reg_op;
    ret_d = next_addr(instr_addr_i);
    target_d = call_target(status_i, instr_i[7:0]);
    if (instr_valid_i && kill_q) begin
      word_d = `NOP_WORD;
    end else if (instr_valid_i) begin
      word_d = instr_i;
    end else begin
      word_d = `NOP_WORD;
    end
  end

  // pending kill: set by a taken skip or a call, held across gaps
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kill_q <= 1'b0;
    end else begin
      kill_q <= kill_d;
    end
  end

  // flush strobe tells fetch that the word after this one is dropped
  // it mirrors the pending kill so fetch sees it the same cycle
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flush_o <= 1'b0;
    end else begin
      flush_o <= kill_d;
    end
  end

  // register file write for the clear-register word
  // the address follows every word; only the strobe qualifies it
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      file_we_o <= 1'b0;
      file_waddr_o <= 5'h00;
      file_wdata_o <= 8'h00;
    end else begin
      file_we_o <= clear_d;
      file_waddr_o <= instr_i[4:0];
      file_wdata_o <= 8'h00;
    end
  end

  // zero flag set strobe, raised by the clear-register word only
  // calls and skips leave the flags alone
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zero_set_o <= 1'b0;
    end else begin
      zero_set_o <= clear_d;
    end
  end

  // return stack push with the address of the following word
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stack_push_o <= 1'b0;
      stack_top_o <= `PC_RESET;
    end else begin
      stack_push_o <= push_d;
      stack_top_o <= ret_d;
    end
  end

  // program counter load with the call target
  // the load and the push share one cycle so the stack sees the
  // old counter value before the new one is taken
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_load_o <= 1'b0;
      program_counter_o <= `PC_RESET;
    end else begin
      pc_load_o <= push_d;
      program_counter_o <= target_d;
    end
  end

  // word that actually runs: a killed word becomes a no-op
  // a gap in fetch also shows as a no-op so nothing stale repeats
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exec_word_o <= `NOP_WORD;
    end else begin
      exec_word_o <= word_d;
    end
  end

  // note for users of this block:
  // the pending kill waits through cycles without a valid word,
  // so a call followed by a fetch stall still drops exactly one
  // word; a second call cannot be taken until that word is gone,
  // which keeps the stack from seeing two pushes for one branch.
  // the register file read must settle within the same cycle,
  // since the tested bit is taken straight from its answer.

endmodule
`default_nettype wire

// ---- reg_file_model.sv ----
// Purpose: register file partner of the decode block
// Assumes: read is combinational on the execute word
// Notes: start pattern is mirrored by the bench model
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input wire sys_clk_i, file_we_o,
  input wire [4:0] file_waddr_o,
  input wire [7:0] file_wdata_o,
  input wire [11:0] instr_i,
  output wire [7:0] file_rdata_i
);
  reg [7:0] mem [0:31];
  integer i;
  // known start pattern, then writes from the block
  initial for (i = 0; i < 32; i = i + 1) mem[i] = i * 37;
  always @(posedge sys_clk_i) if (file_we_o) mem[file_waddr_o] <= file_wdata_o;
  assign file_rdata_i = mem[instr_i[4:0]];
endmodule
`default_nettype wire

// ---- decode_monitor.sv ----
// Purpose: port assertions for the decode block
// Assumes: one clock, reset active low
// Notes: a word counts when valid with no kill pending
`timescale 1ns/1ps
`default_nettype none
module decode_monitor (
  input wire sys_clk_i, rst_b_i, instr_valid_i, flush_o, file_we_o,
  input wire zero_set_o, stack_push_o, pc_load_o,
  input wire [4:0] file_waddr_o,
  input wire [11:0] instr_i, exec_word_o,
  input wire [10:0] instr_addr_i, stack_top_o, program_counter_o,
  input wire [7:0] file_rdata_i, status_i, file_wdata_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // taken word, tested bit, opcode and call target
  wire t = instr_valid_i && !flush_o;
  wire b = file_rdata_i[instr_i[7:5]];
  wire [3:0] o = instr_i[11:8];
  wire [10:0] tg = {status_i[6:5], 1'b0, instr_i[7:0]};
  sequence call_s; t && o == 4'h9; endsequence
  sequence nop_s; exec_word_o == 12'h000 && !stack_push_o && !file_we_o; endsequence
  call_push_a: assert property (
    call_s |=> stack_push_o && stack_top_o == $past(instr_addr_i) + 11'h001)
    else $error("call push");
  call_target_a: assert property (
    call_s |=> pc_load_o && program_counter_o == $past(tg))
    else $error("call target");
  call_flush_a: assert property (
    call_s |=> flush_o && !zero_set_o) else $error("call flush");
  set_hit_a: assert property (
    t && o == 4'h7 && b |=> flush_o && !stack_push_o) else $error("set hit");
  set_miss_a: assert property (
    t && o == 4'h7 && !b |=> !flush_o && !zero_set_o) else $error("set miss");
  clr_hit_a: assert property (
    t && o == 4'h6 && !b |=> flush_o && !pc_load_o) else $error("clr hit");
  clear_reg_a: assert property (
    t && instr_i[11:5] == 7'h03 |=> file_we_o && zero_set_o &&
    file_wdata_o == 8'h00 && file_waddr_o == $past(instr_i[4:0]))
    else $error("clear register");
  flushed_nop_a: assert property (
    flush_o && instr_valid_i |=> nop_s) else $error("flushed word ran");
endmodule
bind bit_skip_call_clear_decode decode_monitor i_mon (.*);
`default_nettype wire

// ---- tb.sv ----
// Purpose: random self-checking bench for the decode block
// Assumes: register file partner answers the addressed register
// Notes: a reference model checks strobes and word every cycle, return, target and clear values only on calls and clears
`timescale 1ns/1ps
`default_nettype none
module tb;
  reg sys_clk_i = 0, rst_b_i = 0, instr_valid_i = 0;
  reg [11:0] instr_i = 12'h000, e, w;
  reg [10:0] instr_addr_i = 11'h000, a, r;
  reg [7:0] status_i = 8'h00;
  reg [15:0] lf = 16'h27D2;
  wire file_we_o, zero_set_o, stack_push_o, pc_load_o, flush_o;
  wire [4:0] file_waddr_o;
  wire [7:0] file_rdata_i, file_wdata_o;
  wire [10:0] stack_top_o, program_counter_o;
  wire [11:0] exec_word_o;
  int num_errors = 0, num_checks = 0, m[32], p = -1, k = 0, i;
  bit t, c, z, h;
  bit_skip_call_clear_decode i_dut (.*);
  reg_file_model i_rf (.*);
  always #12.5 sys_clk_i = ~sys_clk_i;
  function [15:0] nx(input [15:0] v);
    nx = {1'b0, v[15:1]} ^ (v[0] ? 16'hB400 : 16'h0000);
  endfunction
  task chk(input string n, input [12:0] x, y);
    num_checks++;
    if (x !== y) num_errors++;
    if (x !== y) $display("CHECK FAILED %s exp %h got %h", n, y, x);
  endtask
  task complete_run;
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // reset, then random words checked against the model each cycle
  initial begin
    for (i = 0; i < 32; i++) m[i] = i * 37 % 256;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1;
    repeat (3000) begin
      t = instr_valid_i && k == 0;
      h = m[instr_i[4:0]] >> instr_i[7:5];
      c = t && instr_i[11:8] == 4'h9;
      z = t && instr_i[11:5] == 7'h03;
      if (t) k = c || instr_i[11:8] == 4'h7 && h || instr_i[11:8] == 4'h6 && !h;
      else if (instr_valid_i) k = 0;
      e = {c, c, z, z, k[0]};
      w = t ? instr_i : 12'h000;
      a = {status_i[6:5], 1'b0, instr_i[7:0]};
      r = instr_addr_i + 11'h001;
      @(posedge sys_clk_i);
      if (p >= 0) m[p] = 0;
      p = z ? instr_i[4:0] : -1;
      lf = nx(lf);
      instr_valid_i <= lf[15:13] != 3'h0;
      instr_i <= lf[1:0] == 2'h0 ? {7'h03, lf[9:5]} :
        {lf[1:0] == 2'h1 ? 4'h9 : {3'h3, lf[0]}, lf[12:5]};
      lf = nx(lf);
      status_i <= lf[7:0];
      instr_addr_i <= lf[15:5];
      #1;
      chk("strobes", {stack_push_o, pc_load_o, file_we_o, zero_set_o, flush_o}, e);
      chk("word", exec_word_o, w);
      if (c) chk("return", stack_top_o, r);
      if (c) chk("target", program_counter_o, a);
      if (z) chk("clear", {file_waddr_o, file_wdata_o}, {p[4:0], 8'h00});
    end
    complete_run;
  end
endmodule
`default_nettype wire
